// ===== hdl/vic_backup_store.v
// Purpose: one-context backup of working, status and pointer registers
// Assumes: save and restore never in the same cycle
// Notes:   read data registered; a new save overwrites the old
`timescale 1ns/1ps
`default_nettype none
module vic_backup_store #(
  parameter W = 8
) (
  input  wire         refClk,
  input  wire         rstN,
  input  wire         saveEn,
  input  wire [W-1:0] workIn,
  input  wire [W-1:0] statIn,
  input  wire [W-1:0] ptrIn,
  output reg  [W-1:0] workOut,
  output reg  [W-1:0] statOut,
  output reg  [W-1:0] ptrOut
);
  // single slot: a nested save replaces the held context
  always @(posedge refClk or negedge rstN) begin
    if (!rstN) begin
      workOut <= {W{1'b0}};
      statOut <= {W{1'b0}};
      ptrOut  <= {W{1'b0}};
    end else if (saveEn) begin
      workOut <= workIn; // [RQ12] [RQ13]
      statOut <= statIn;
      ptrOut  <= ptrIn;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/vic_consts.vh
// Purpose: shared constants of the vectored interrupt controller
// Assumes: included by bare name from design files
// Notes:   definitions only
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH

// Wishbone register offsets (byte addresses)
`define VIC_OFS_FLAG     8'h00
`define VIC_OFS_ENABLE   8'h04
`define VIC_OFS_IRQMASK  8'h08
`define VIC_OFS_CTRL     8'h0C
`define VIC_OFS_PEND     8'h10
`define VIC_OFS_VECTOR   8'h14

// control register fields
`define VIC_CTRL_GIE     0
`define VIC_CTRL_LXT     1
`define VIC_CTRL_BKUP    2

// source count and vector widths
`define VIC_NSRC_FULL    18
`define VIC_NSRC_SMALL   13
`define VIC_VEC_W        10
`define VIC_VEC_RESET    10'h000
`define VIC_VEC_EXT      10'h003

// noise filter: eight system clocks
`define VIC_FILT_CLKS    8
`define VIC_FILT_CNT_W   4

`endif

// ===== hdl/vic_pin_filter.v
// Purpose: noise filter and falling-edge detector on the external pin
// Assumes: pin already synchronous to refClk
// Notes:   filter bypassed in low-frequency crystal mode
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.vh"
module vic_pin_filter (
  input  wire refClk,
  input  wire rstN,
  input  wire pinIn,
  input  wire lowFreqXtalMode,
  output reg  fallPulse
);
  reg                         stable_q;
  reg                         prev_q;
  reg [`VIC_FILT_CNT_W-1:0]   cnt_q;
  wire                        filtered;

  // level must differ for eight clocks before it is accepted
  always @(posedge refClk or negedge rstN) begin
    if (!rstN) begin
      stable_q <= 1'b1;
      cnt_q    <= {`VIC_FILT_CNT_W{1'b0}};
    end else if (pinIn == stable_q) begin
      cnt_q <= {`VIC_FILT_CNT_W{1'b0}};
    end else if (cnt_q == `VIC_FILT_CLKS - 1) begin
      stable_q <= pinIn; // [RQ9]
      cnt_q    <= {`VIC_FILT_CNT_W{1'b0}};
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign filtered = lowFreqXtalMode ? pinIn : stable_q; // [RQ10]

  // falling edge raises one pulse
  always @(posedge refClk or negedge rstN) begin
    if (!rstN) begin
      prev_q    <= 1'b1;
      fallPulse <= 1'b0;
    end else begin
      prev_q    <= filtered;
      fallPulse <= prev_q & ~filtered; // [RQ11]
    end
  end
endmodule
`default_nettype wire

// ===== hdl/vic_top.v
// Purpose: vectored interrupt controller for a small 8-bit core
// Assumes: core signals synchronous to refClk; Wishbone classic slave
// Notes:   source 0 is the external pin, source 1 the pin-change port
//          map: 00 flags (write one to clear), 04 enables, 08 irq mask,
//          0C control, 10 pending, 14 last vector taken
//          one backup slot only: a nested entry loses the outer context
//          the priority scan is a plain loop, cheap at eighteen inputs
//          outputs are all registered; irq trails the flags by a clock
// Behaviour
// [RQ1] The full build serves eighteen sources, each with fixed vector and priority.
// [RQ2] A reduced build serves thirteen sources with the same vectors.
// [RQ3] A source is taken only with global enable and its own enable set.
// [RQ4] An enabled request redirects the next fetch to its vector.
// [RQ5] Flags record each request and enable bits mask each source.
// [RQ6] Flags other than pin-change set whatever the enables.
// [RQ7] Software clears the serviced flag before leaving the routine.
// [RQ8] Return from service ends the routine and sets global enable.
// [RQ9] The external pin filter drops pulses shorter than eight clocks.
// [RQ10] Low-frequency crystal mode bypasses the noise filter.
// [RQ11] A falling pin edge raises the external request at its vector.
// [RQ12] Hardware saves working, status and pointer registers on entry.
// [RQ13] The backup holds one context, overwritten by a nested entry.
// [RQ14] Hardware restores the three registers when the routine ends.
// [RQ15] The lowest priority number among pending requests goes first.
// [RQ16] Vectoring clears the global enable.
//
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "vic_consts.vh"
module vic_top #(
  parameter FULL = 1,
  parameter W    = 8
) (
  input  wire                   ref_clk,
  input  wire                   rst_n,
  // wishbone classic slave
  input  wire                   wb_cyc_i,
  input  wire                   wb_stb_i,
  input  wire                   wb_we_i,
  input  wire [7:0]             wb_adr_i,
  input  wire [3:0]             wb_sel_i,
  input  wire [31:0]            wb_dat_i,
  output reg  [31:0]            wb_dat_o,
  output reg                    wb_ack_o,
  // event sources, one-cycle pulses; bits 0 and 1 unused (external pin, pin-change port)
  input  wire [17:0]            srcEvent,
  input  wire                   extPin,
  input  wire                   portPinChange,
  // core instruction interface
  input  wire                   globalIrqOnInstr,
  input  wire                   globalIrqOffInstr,
  input  wire                   returnFromServiceInstr,
  input  wire [W-1:0]           workingRegister,
  input  wire [W-1:0]           coreStatusRegister,
  input  wire [W-1:0]           indirectPointerRegister,
  output reg                    vectorTake,
  output reg  [`VIC_VEC_W-1:0]  vectorAddr,
  output reg                    restoreStrobe,
  output reg  [W-1:0]           restoreWorking,
  output reg  [W-1:0]           restoreStatus,
  output reg  [W-1:0]           restorePointer,
  output reg                    irq
);
  localparam N = `VIC_NSRC_FULL;
  // sources kept by the reduced build (no voltage, comparator one, bus)
  localparam [N-1:0] SMALL_SET = 18'h0_7FE7;

  // register state
  reg  [N-1:0]            flag_q;
  reg  [N-1:0]            enable_q;
  reg  [N-1:0]            irqMask_q;
  reg                     gie_q;
  reg                     lxt_q;
  reg                     inService_q;
  reg  [`VIC_VEC_W-1:0]   lastVec_q;
  reg                     restorePend_q;

  // combinational nets
  wire                    extFall;
  wire [N-1:0]            present;
  wire [N-1:0]            rawEvent;
  wire [N-1:0]            pend;
  wire [W-1:0]            bkWork;
  wire [W-1:0]            bkStat;
  wire [W-1:0]            bkPtr;
  wire                    wbReq;
  wire                    wbWr;
  wire [N-1:0]            clrMask;
  wire                    wrFlag;
  wire                    wrEnable;
  wire                    wrMask;
  wire                    wrCtrl;

  // priority scan result
  reg  [`VIC_VEC_W-1:0]   winVec;
  reg                     anyWin;
  integer                 i;

  // fixed vector per source, in priority order
  // the bus sources skip ahead to 036; reset stays at vector zero
  function [`VIC_VEC_W-1:0] vecOf;
    input integer k;
    begin
      case (k)
        0:       vecOf = `VIC_VEC_EXT;
        1:       vecOf = 10'h006;
        2:       vecOf = 10'h009;
        3:       vecOf = 10'h00C;
        4:       vecOf = 10'h00F;
        5:       vecOf = 10'h012;
        6:       vecOf = 10'h015;
        7:       vecOf = 10'h018;
        8:       vecOf = 10'h01B;
        9:       vecOf = 10'h01E;
        10:      vecOf = 10'h021;
        11:      vecOf = 10'h024;
        12:      vecOf = 10'h027;
        13:      vecOf = 10'h02A;
        14:      vecOf = 10'h02D;
        15:      vecOf = 10'h036;
        16:      vecOf = 10'h039;
        17:      vecOf = 10'h03F;
        default: vecOf = `VIC_VEC_RESET;
      endcase
    end
  endfunction

  // reduced build drops voltage detect, comparator one and bus sources;
  // absent sources read zero and can never be enabled or flagged
  assign present = (FULL != 0) ? {N{1'b1}} : SMALL_SET; // [RQ1] [RQ2]

  // external pin: noise filter, then falling-edge detect
  vic_pin_filter u_filter (
    .refClk          (ref_clk),
    .rstN            (rst_n),
    .pinIn           (extPin),
    .lowFreqXtalMode (lxt_q),
    .fallPulse       (extFall)
  );

  // context saved at the edge that ends the vector cycle
  vic_backup_store #(.W(W)) u_backup (
    .refClk  (ref_clk),
    .rstN    (rst_n),
    .saveEn  (vectorTake),
    .workIn  (workingRegister),
    .statIn  (coreStatusRegister),
    .ptrIn   (indirectPointerRegister),
    .workOut (bkWork),
    .statOut (bkStat),
    .ptrOut  (bkPtr)
  );

  // pin-change flag only sets while its enable is on
  assign rawEvent = {srcEvent[17:2],
                     portPinChange & enable_q[1],
                     extFall} & present; // [RQ6] [RQ11]

  // pending means flagged and enabled; the global enable gates the take
  assign pend = flag_q & enable_q & present; // [RQ3]

  // a request is taken once; the strobe still held during ack is ignored
  assign wbReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wbWr    = wbReq & wb_we_i;
  // one write strobe per register; control honours byte lane zero only
  assign wrFlag   = wbWr && (wb_adr_i == `VIC_OFS_FLAG);
  assign wrEnable = wbWr && (wb_adr_i == `VIC_OFS_ENABLE);
  assign wrMask   = wbWr && (wb_adr_i == `VIC_OFS_IRQMASK);
  assign wrCtrl   = wbWr && (wb_adr_i == `VIC_OFS_CTRL) && wb_sel_i[0];
  assign clrMask  = wrFlag ? wb_dat_i[N-1:0] : {N{1'b0}};

  // fixed priority: lowest index wins; the scan runs downward so the
  // last hit, the lowest pending index, is the one that sticks
  always @* begin
    winVec = `VIC_VEC_RESET;
    anyWin = 1'b0;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (pend[i]) begin
        winVec = vecOf(i); // [RQ15]
        anyWin = 1'b1;
      end
    end
  end

  // sticky flags: set beats write-one clear
  // so an event landing with its own clear is never lost
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= {N{1'b0}};
    end else begin
      flag_q <= (flag_q & ~clrMask) | rawEvent; // [RQ5] [RQ6] [RQ7]
    end
  end

  // global enable and vectoring; a take wins over any instruction in the
  // same cycle, so the routine always starts with the enable cleared
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gie_q       <= 1'b0;
      inService_q <= 1'b0;
      vectorTake  <= 1'b0;
      vectorAddr  <= `VIC_VEC_RESET;
      lastVec_q   <= `VIC_VEC_RESET;
    end else begin
      vectorTake <= 1'b0;
      if (gie_q && anyWin && !vectorTake) begin
        vectorTake  <= 1'b1; // [RQ4]
        vectorAddr  <= winVec;
        lastVec_q   <= winVec;
        gie_q       <= 1'b0; // [RQ16]
        inService_q <= 1'b1;
      end else if (returnFromServiceInstr) begin
        gie_q       <= 1'b1; // [RQ8]
        inService_q <= 1'b0;
      end else if (globalIrqOnInstr) begin
        gie_q <= 1'b1; // [RQ3]
      end else if (globalIrqOffInstr) begin
        gie_q <= 1'b0; // [RQ3]
      end else if (wrCtrl) begin
        gie_q <= wb_dat_i[`VIC_CTRL_GIE];
      end
    end
  end

  // restore the saved context on return
  // a return outside a routine has nothing saved and is ignored
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      restorePend_q  <= 1'b0;
      restoreStrobe  <= 1'b0;
      restoreWorking <= {W{1'b0}};
      restoreStatus  <= {W{1'b0}};
      restorePointer <= {W{1'b0}};
    end else begin
      restorePend_q <= returnFromServiceInstr & inService_q;
      restoreStrobe <= restorePend_q; // [RQ14]
      if (restorePend_q) begin
        restoreWorking <= bkWork; // [RQ14]
        restoreStatus  <= bkStat;
        restorePointer <= bkPtr;
      end
    end
  end

  // enables, irq mask and mode bits
  // enable and mask only keep bits of sources that exist
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q  <= {N{1'b0}};
      irqMask_q <= {N{1'b0}};
      lxt_q     <= 1'b0;
    end else begin
      if (wrEnable) begin
        enable_q <= wb_dat_i[N-1:0] & present; // [RQ5]
      end
      if (wrMask) begin
        irqMask_q <= wb_dat_i[N-1:0] & present;
      end
      // crystal mode is a software setting here, no clock sensing
      if (wrCtrl) begin
        lxt_q <= wb_dat_i[`VIC_CTRL_LXT]; // [RQ10]
      end
    end
  end

  // bus answer one cycle after the request; unmapped reads zero
  // data is cleared on idle cycles so a stale word never sits there
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= 32'h0000_0000;
      if (wbReq && !wb_we_i) begin
        case (wb_adr_i)
          `VIC_OFS_FLAG:    wb_dat_o <= {14'h0, flag_q};
          `VIC_OFS_ENABLE:  wb_dat_o <= {14'h0, enable_q};
          `VIC_OFS_IRQMASK: wb_dat_o <= {14'h0, irqMask_q};
          `VIC_OFS_CTRL:    wb_dat_o <= {29'h0, inService_q,
                                         lxt_q, gie_q};
          `VIC_OFS_PEND:    wb_dat_o <= {14'h0, pend};
          `VIC_OFS_VECTOR:  wb_dat_o <= {22'h0, lastVec_q};
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // level interrupt from unmasked sticky flags
  // registered, so it trails the flags by one clock
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_q & irqMask_q);
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench of the interrupt controller
// Assumes: core model on the instruction side
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        refClk, rstN, wbCyc, wbStb, wbWe, wbAck, irq, extPin;
  logic        pinChg, onReq, offReq, retReq, vecTake, rstStb, gOn;
  logic        gOff, gRet;
  logic [7:0]  wbAdr, work, stat, ptr, resW, resS, resP;
  logic [9:0]  vecAddr;
  logic [17:0] srcEvent;
  logic [31:0] wbDat, wbDatO;
  int          errCount, testsRun, cycles;

  vic_top i_vic_top (
    .ref_clk(refClk), .rst_n(rstN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDat),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .srcEvent(srcEvent),
    .extPin(extPin), .portPinChange(pinChg), .globalIrqOnInstr(gOn),
    .globalIrqOffInstr(gOff), .returnFromServiceInstr(gRet),
    .workingRegister(work), .coreStatusRegister(stat),
    .indirectPointerRegister(ptr), .vectorTake(vecTake),
    .vectorAddr(vecAddr), .restoreStrobe(rstStb), .restoreWorking(resW),
    .restoreStatus(resS), .restorePointer(resP), .irq(irq));
  vic_core_model i_vic_core_model (
    .refClk(refClk), .rstN(rstN), .onReq(onReq), .offReq(offReq),
    .retReq(retReq), .globalIrqOnInstr(gOn), .globalIrqOffInstr(gOff),
    .returnFromServiceInstr(gRet), .workingRegister(work),
    .coreStatusRegister(stat), .indirectPointerRegister(ptr));

  always #4 refClk = ~refClk;
  // hang guard, the run needs well under a thousand cycles
  always @(posedge refClk) begin
    cycles++;
    if (cycles == 5000) begin
      errCount++;
      wrapUp;
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    testsRun++;
    if (s !== e) begin
      errCount++;
      $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // classic single cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge refClk);
    end while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge refClk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic ev(input int i);
    srcEvent <= 18'h1 << i;
    @(posedge refClk);
    srcEvent <= 18'h0;
  endtask
  task automatic core(input logic on, input logic off, input logic ret);
    onReq <= on;
    offReq <= off;
    retReq <= ret;
    @(posedge refClk);
    onReq <= 1'b0;
    offReq <= 1'b0;
    retReq <= 1'b0;
  endtask
  // low for n clocks, then idle long enough to settle the filter
  task automatic pin(input int n);
    extPin <= 1'b0;
    repeat (n) @(posedge refClk);
    extPin <= 1'b1;
    repeat (12) @(posedge refClk);
  endtask
  task automatic waitVec(input logic [9:0] a, output logic [7:0] w);
    int n;
    n = 0;
    do begin
      @(posedge refClk);
      n++;
    end while (vecTake !== 1'b1 && n < 20);
    chk(vecTake, 1'b1);
    chk(vecAddr, a);
    w = work;
  endtask

  task automatic tRegs;
    rd(8'h0, 32'h0);
    wr(8'h4, 32'h3_FFFF);
    rd(8'h4, 32'h3_FFFF);
    wr(8'h4, 32'h0);
    rd(8'h1C, 32'h0);
  endtask
  task automatic tFlags;
    ev(5);
    pinChg <= 1'b1;
    @(posedge refClk);
    pinChg <= 1'b0;
    rd(8'h0, 32'h20);
    chk(irq, 1'b0);
    wr(8'h8, 32'h20);
    chk(irq, 1'b1);
    wr(8'h0, 32'h20);
    chk(irq, 1'b0);
    wr(8'h8, 32'h0);
  endtask
  // two pending sources, nested entry, then one return
  task automatic tNest;
    logic [7:0] w;
    int n;
    wr(8'h4, 32'h2_0008);
    ev(17);
    @(posedge refClk);
    ev(3);
    repeat (4) @(posedge refClk);
    chk(vecTake, 1'b0);
    rd(8'h10, 32'h2_0008);
    core(1'b1, 1'b0, 1'b0);
    waitVec(10'hC, w);
    repeat (4) @(posedge refClk);
    chk(vecTake, 1'b0);
    wr(8'h0, 32'h8);
    core(1'b1, 1'b0, 1'b0);
    waitVec(10'h3F, w);
    wr(8'h0, 32'h2_0000);
    core(1'b0, 1'b0, 1'b1);
    n = 0;
    while (rstStb !== 1'b1 && n < 20) begin
      @(posedge refClk);
      n++;
    end
    chk(rstStb, 1'b1);
    chk({resW, resS, resP}, {w, ~w, w ^ 8'h5A});
    rd(8'hC, 32'h1);
    core(1'b0, 1'b1, 1'b0);
    @(posedge refClk);
    rd(8'hC, 32'h0);
    wr(8'h4, 32'h0);
  endtask
  task automatic tPin;
    logic [7:0] w;
    wr(8'h4, 32'h1);
    pin(7);
    rd(8'h0, 32'h0);
    pin(8);
    rd(8'h0, 32'h1);
    core(1'b1, 1'b0, 1'b0);
    waitVec(10'h3, w);
    wr(8'h0, 32'h1);
    core(1'b0, 1'b0, 1'b1);
    wr(8'hC, 32'h2);
    pin(1);
    rd(8'h0, 32'h1);
  endtask

  task automatic wrapUp;
    $display("mismatches %0d checks %0d", errCount, testsRun);
    if (errCount == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    refClk = 1'b0;
    rstN = 1'b0;
    {wbCyc, wbStb, wbWe, pinChg, onReq, offReq, retReq} = 7'h0;
    extPin = 1'b1;
    wbAdr = 8'h0;
    wbDat = 32'h0;
    srcEvent = 18'h0;
    errCount = 0;
    testsRun = 0;
    cycles = 0;
    repeat (20) @(posedge refClk);
    rstN <= 1'b1;
    @(posedge refClk);
    tRegs;
    tFlags;
    tNest;
    tPin;
    wrapUp;
  end
endmodule
`default_nettype wire

// ===== tb/vic_core_model.sv
// Purpose: core side model issuing enable and return instructions
// Assumes: requests come from the bench one cycle ahead
// Notes:   context moves every cycle so each save differs
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  input  wire logic       refClk,
  input  wire logic       rstN,
  input  wire logic       onReq,
  input  wire logic       offReq,
  input  wire logic       retReq,
  output logic            globalIrqOnInstr,
  output logic            globalIrqOffInstr,
  output logic            returnFromServiceInstr,
  output logic      [7:0] workingRegister,
  output logic      [7:0] coreStatusRegister,
  output logic      [7:0] indirectPointerRegister
);
  logic [7:0] cntQ;
  // three distinct views of one running count
  assign workingRegister = cntQ;
  assign coreStatusRegister = ~cntQ;
  assign indirectPointerRegister = cntQ ^ 8'h5A;

  // decode takes one cycle, like a fetch stage
  always_ff @(posedge refClk or negedge rstN) begin
    if (!rstN) begin
      cntQ <= 8'h0;
      globalIrqOnInstr <= 1'b0;
      globalIrqOffInstr <= 1'b0;
      returnFromServiceInstr <= 1'b0;
    end else begin
      cntQ <= cntQ + 8'h1;
      globalIrqOnInstr <= onReq;
      globalIrqOffInstr <= offReq;
      returnFromServiceInstr <= retReq;
    end
  end
endmodule
`default_nettype wire

// ===== tb/vic_top_sva.sv
// Purpose: port checker of the interrupt controller
// Assumes: one clock domain, reset async low
// Notes:   shadows the saved context to judge restores
`timescale 1ns/1ps
`default_nettype none
module vic_top_chk #(
  parameter W = 8
) (
  input wire logic         ref_clk,
  input wire logic         rst_n,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_we_i,
  input wire logic         wb_ack_o,
  input wire logic         globalIrqOnInstr,
  input wire logic         returnFromServiceInstr,
  input wire logic [W-1:0] workingRegister,
  input wire logic [W-1:0] coreStatusRegister,
  input wire logic [W-1:0] indirectPointerRegister,
  input wire logic         vectorTake,
  input wire logic [9:0]   vectorAddr,
  input wire logic         restoreStrobe,
  input wire logic [W-1:0] restoreWorking,
  input wire logic [W-1:0] restoreStatus,
  input wire logic [W-1:0] restorePointer
);
  logic [3*W-1:0] ctxQ;
  logic           svcQ;
  // anything that may turn the global enable back on
  wire logic gieSet = globalIrqOnInstr | returnFromServiceInstr |
                      (wb_cyc_i & wb_stb_i & wb_we_i);

  // context as the core showed it while the vector was taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctxQ <= '0;
      svcQ <= 1'b0;
    end else if (vectorTake) begin
      ctxQ <= {workingRegister, coreStatusRegister,
               indirectPointerRegister};
      svcQ <= 1'b1;
    end else if (returnFromServiceInstr) begin
      svcQ <= 1'b0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  vec_legal_a: assert property (vectorTake |->
    (vectorAddr % 3 == 0 && vectorAddr >= 10'h3 && vectorAddr <= 10'h2D)
    || vectorAddr inside {10'h36, 10'h39, 10'h3F})
    else $error("vector outside the table");
  vec_pulse_a: assert property (vectorTake |=> !vectorTake)
    else $error("vector take longer than one cycle");
  gie_clear_a: assert property (
    (vectorTake && !gieSet) ##1 !gieSet [*2] |=> !vectorTake)
    else $error("vectored again with enable cleared");
  ret_restore_a: assert property (
    returnFromServiceInstr && svcQ |-> ##[1:2] restoreStrobe)
    else $error("return gave no restore");
  restore_cause_a: assert property (restoreStrobe |->
    $past(returnFromServiceInstr) || $past(returnFromServiceInstr, 2))
    else $error("restore without return");
  ctx_match_a: assert property (restoreStrobe |->
    {restoreWorking, restoreStatus, restorePointer} == ctxQ)
    else $error("restored context differs from saved");
  ack_next_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule

bind vic_top vic_top_chk #(.W(W)) i_vic_top_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .globalIrqOnInstr(globalIrqOnInstr),
  .returnFromServiceInstr(returnFromServiceInstr),
  .workingRegister(workingRegister),
  .coreStatusRegister(coreStatusRegister),
  .indirectPointerRegister(indirectPointerRegister),
  .vectorTake(vectorTake), .vectorAddr(vectorAddr),
  .restoreStrobe(restoreStrobe), .restoreWorking(restoreWorking),
  .restoreStatus(restoreStatus), .restorePointer(restorePointer));
`default_nettype wire
